// ===== hw/boot_seq_pkg.sv
// Constants, register map and field layout shared by both ends of the boot-mode link.
// Assumes both ends run on the one 50 MHz clock hclk with the active-low reset hresetn.
// Notes on behaviour
// - ROM sequence runs first, chosen by strap.
// - Strap 00: point flash entry locally, halt.
// - Core-only reset clears the alias bit.
// - Strap 01: halt and await service processor.
// - Controller writes halt code into control byte.
// - Inactive boot code reports about-to-halt status.
// - Controller waits for status before register access.
// - Controller configures, then issues core-only reset.
// - Strap 10: scan links for pending ones.
// - Strap 10 halt request: report, halt at once.
// - Strap 10: return routes from interface units.
// - Strap 10 all links active: report, halt.
// - Link-init: remote configures, then core-only reset.
// - First neighbour message writes route back.
// - Strap 11 halt request: halt, skip links.
// - State field above three means not active.
// - Strap 11: routes from interface and config units.
// - Firmware agent found: point regions, enable firmware.
// - Then stop scanning, write core reset kind.
// - Strap 11 all active, no agent: halt.
package boot_seq_pkg;

   // Default sizes.
   localparam int NLINK = 4;
   localparam int LSTATE_W = 4;
   localparam int NID_W = 8;
   localparam int SEG_W = 4;
   localparam int AGENT_W = 4;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int NB_W = 16;
   localparam int SYNC_STAGES = 2;

   // Boot-mode strap encodings.
   localparam logic [1:0] MODE_FLASH = 2'h0;
   localparam logic [1:0] MODE_SVC = 2'h1;
   localparam logic [1:0] MODE_LINK_INIT = 2'h2;
   localparam logic [1:0] MODE_LINK_BOOT = 2'h3;

   // Scratchpad codes, link state limit and reset kind.
   localparam logic [7:0] HALT_REQ = 8'h01;
   localparam logic [7:0] ABOUT_TO_HALT = 8'hf8;
   localparam logic [LSTATE_W-1:0] LINK_ACTIVE_MAX = 4'h3;
   localparam logic [2:0] RST_KIND_CORE = 3'h1;

   // Register indices on the configuration port.
   localparam logic [ADDR_W-1:0] REG_SCRATCH = 4'h0;
   localparam logic [ADDR_W-1:0] REG_SAD_FLASH = 4'h1;
   localparam logic [ADDR_W-1:0] REG_BIOS_SEG = 4'h2;
   localparam logic [ADDR_W-1:0] REG_REGION = 4'h3;
   localparam logic [ADDR_W-1:0] REG_SW_RESET = 4'h4;
   localparam logic [ADDR_W-1:0] REG_ROUTES = 4'h5;
   localparam logic [ADDR_W-1:0] REG_MODE = 4'h6;

   // Field positions.
   localparam int SCR_STATUS_LSB = 0;
   localparam int SCR_CTRL_LSB = 8;
   localparam int SAD_EN_BIT = 8;
   localparam int RGN_FW_LSB = 0;
   localparam int RGN_BIOS_LSB = 8;
   localparam int RGN_IOHUB_LSB = 16;
   localparam int RGN_FW_EN_BIT = 24;
   localparam int NB_SRC_SIU_BIT = 8;
   localparam int NB_SRC_CFG_BIT = 9;
   localparam int NB_AGENT_LSB = 12;

   // Controller registers on AHB-Lite (byte addresses) and their fields.
   localparam logic [31:0] AHB_CTRL = 32'h0000_0000;
   localparam logic [31:0] AHB_STATUS = 32'h0000_0004;
   localparam int AHB_IDX_LSB = 2;
   localparam int CTL_GO_BIT = 0;
   localparam int CTL_NID_LSB = 8;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // True when a link state field shows the link active.
   function automatic logic link_active(input logic [LSTATE_W-1:0] st);
      return st <= LINK_ACTIVE_MAX;
   endfunction

endpackage

// ===== hw/boot_link_if.sv
// Interface joining the socket's boot sequencer to its controlling party.
// Assumes both parties are clocked by the same hclk; the bench resolves nothing here.
`timescale 1ns/1ps
interface boot_link_if;
   // Configuration access from controller to device; req held until ack.
   logic cfg_req;
   logic cfg_we;
   logic [boot_seq_pkg::ADDR_W-1:0] cfg_addr;
   logic [boot_seq_pkg::DATA_W-1:0] cfg_wdata;
   logic cfg_ack;
   logic [boot_seq_pkg::DATA_W-1:0] cfg_rdata;
   // Core-only reset pulse from controller.
   logic core_rst;
   // Route-back message from the device to the neighbour; req held until ack.
   logic nb_req;
   logic [1:0] nb_link;
   logic [boot_seq_pkg::NB_W-1:0] nb_data;
   logic nb_ack;

   modport dev (input cfg_req, cfg_we, cfg_addr, cfg_wdata, core_rst, nb_ack,
                output cfg_ack, cfg_rdata, nb_req, nb_link, nb_data);
   modport ctl (output cfg_req, cfg_we, cfg_addr, cfg_wdata, core_rst, nb_ack,
                input cfg_ack, cfg_rdata, nb_req, nb_link, nb_data);
endinterface

// ===== hw/boot_seq_device.sv
// Strap-selected boot sequencer of one processor socket.
// Assumes link state inputs come from logic on hclk; the strap pins are asynchronous.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module boot_seq_device #(
   parameter int NL = boot_seq_pkg::NLINK,
   parameter logic [boot_seq_pkg::NID_W-1:0] LOCAL_NID = 8'h00
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Boot-mode strap pins.
   input wire logic [1:0] boot_strap,
   // Link layer status.
   input wire logic [NL*boot_seq_pkg::LSTATE_W-1:0] link_state,
   input wire logic [NL*boot_seq_pkg::AGENT_W-1:0] link_agents,
   input wire logic [NL-1:0] link_fw_agent,
   input wire logic [NL*boot_seq_pkg::NID_W-1:0] link_fw_nid,
   // Link to the controlling party.
   boot_link_if.dev lnk,
   // Core control and visible state.
   output logic core_halt_q,
   output logic alias_q,
   output logic core_reset_q,
   output logic [1:0] boot_mode_q,
   output logic [7:0] status_q,
   output logic [boot_seq_pkg::DATA_W-1:0] sad_flash_q
);

   // Sequencer states, Gray coded along capture, dispatch, scan, route, halt, run.
   typedef enum logic [2:0] {
      S_CAPTURE = 3'b000,
      S_DISPATCH = 3'b001,
      S_SCAN = 3'b011,
      S_ROUTE = 3'b010,
      S_HALT = 3'b110,
      S_RUN = 3'b111
   } dev_state_t;

   dev_state_t state_q; // Sequencer state.
   logic [1:0] strap_s1_q; // First synchroniser stage.
   logic [1:0] strap_s2_q; // Second synchroniser stage.
   logic [1:0] cap_cnt_q; // Cycles since reset release.
   logic [1:0] idx_q; // Link under examination.
   logic [NL-1:0] done_q; // Links whose return routes are programmed.
   logic [7:0] ctl_byte_q; // Scratchpad control byte.
   logic [boot_seq_pkg::DATA_W-1:0] bios_seg_q; // BIOS segment enables.
   logic [boot_seq_pkg::DATA_W-1:0] region_q; // Firmware, BIOS and I/O hub targets.
   logic [2:0] sw_reset_q; // Software reset register, reset-kind field.
   logic cfg_ack_q; // Configuration answer strobe.
   logic [boot_seq_pkg::DATA_W-1:0] cfg_rdata_q; // Configuration read data.
   logic nb_req_q; // Route-back message pending.
   logic [boot_seq_pkg::NB_W-1:0] nb_data_q; // Route-back message body.

   logic cap_done; // Strap synchroniser has filled.
   logic halt_req; // Controller asked for a halt.
   logic all_done; // Every link is active and routed.
   logic cur_active; // Link under examination is active.
   logic cfg_take; // A configuration access is taken this cycle.
   logic cfg_wr_rst; // Configuration write requests a core-only reset.
   logic fw_fire; // Firmware agent found on the link just routed.
   logic core_evt; // Core-only reset happens this cycle.

   assign cap_done = cap_cnt_q == 2'(boot_seq_pkg::SYNC_STAGES);
   assign halt_req = ctl_byte_q == boot_seq_pkg::HALT_REQ;
   assign all_done = &done_q;
   assign cur_active = boot_seq_pkg::link_active(
      link_state[idx_q*boot_seq_pkg::LSTATE_W +: boot_seq_pkg::LSTATE_W]);
   assign cfg_take = lnk.cfg_req && !cfg_ack_q;
   assign cfg_wr_rst = cfg_take && lnk.cfg_we && lnk.cfg_addr == boot_seq_pkg::REG_SW_RESET
      && lnk.cfg_wdata[2:0] == boot_seq_pkg::RST_KIND_CORE;
   assign fw_fire = state_q == S_ROUTE && lnk.nb_ack
      && boot_mode_q == boot_seq_pkg::MODE_LINK_BOOT && link_fw_agent[idx_q];
   assign core_evt = lnk.core_rst || cfg_wr_rst || fw_fire;

   assign lnk.cfg_ack = cfg_ack_q;
   assign lnk.cfg_rdata = cfg_rdata_q;
   assign lnk.nb_req = nb_req_q;
   assign lnk.nb_link = idx_q;
   assign lnk.nb_data = nb_data_q;

   // Two-flop synchroniser on the strap pins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_s1_q <= 2'h0;
         strap_s2_q <= 2'h0;
      end else begin
         strap_s1_q <= boot_strap;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Captures the strap once the synchroniser has filled, then never again.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_cnt_q <= 2'h0;
         boot_mode_q <= 2'h0;
      end else if (state_q == S_CAPTURE) begin
         if (cap_done) begin
            boot_mode_q <= strap_s2_q;
         end else begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
         end
      end
   end

   // Main sequence; a core-only reset overrides every state once the mode is known.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= S_CAPTURE;
         idx_q <= 2'h0;
      end else if (core_evt && state_q != S_CAPTURE) begin
         state_q <= S_RUN;
      end else begin
         case (state_q)
            S_CAPTURE: begin
               if (cap_done) begin
                  state_q <= S_DISPATCH;
               end
            end
            S_DISPATCH: begin
               // Flash and service modes halt; link modes start discovery.
               if (boot_mode_q[1]) begin
                  state_q <= S_SCAN;
               end else begin
                  state_q <= S_HALT;
               end
            end
            S_SCAN: begin
               if (halt_req) begin
                  state_q <= S_HALT;
               end else if (all_done) begin
                  state_q <= S_HALT;
               end else if (!done_q[idx_q] && cur_active) begin
                  state_q <= S_ROUTE;
               end else begin
                  idx_q <= idx_q + 2'h1;
               end
            end
            S_ROUTE: begin
               // The firmware path is taken by the reset override above.
               if (lnk.nb_ack) begin
                  state_q <= S_SCAN;
                  idx_q <= idx_q + 2'h1;
               end
            end
            S_HALT: begin
               state_q <= S_HALT;
            end
            S_RUN: begin
               state_q <= S_RUN;
            end
            default: begin
               state_q <= S_CAPTURE;
            end
         endcase
      end
   end

   // Route-back message: the first thing sent to a newly active neighbour.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nb_req_q <= 1'b0;
         nb_data_q <= '0;
         done_q <= '0;
      end else if (state_q == S_SCAN && !halt_req && !all_done && !done_q[idx_q]
                   && cur_active && !core_evt) begin
         nb_req_q <= 1'b1;
         nb_data_q <= '0;
         nb_data_q[boot_seq_pkg::NID_W-1:0] <= LOCAL_NID;
         nb_data_q[boot_seq_pkg::NB_SRC_SIU_BIT] <= 1'b1;
         nb_data_q[boot_seq_pkg::NB_SRC_CFG_BIT] <=
            boot_mode_q == boot_seq_pkg::MODE_LINK_BOOT;
         nb_data_q[boot_seq_pkg::NB_AGENT_LSB +: boot_seq_pkg::AGENT_W] <=
            link_agents[idx_q*boot_seq_pkg::AGENT_W +: boot_seq_pkg::AGENT_W];
      end else if (nb_req_q && lnk.nb_ack) begin
         nb_req_q <= 1'b0;
         done_q[idx_q] <= 1'b1;
      end
   end

   // Scratchpad: the controller owns the control byte, the sequencer the status byte.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_byte_q <= 8'h00;
         status_q <= 8'h00;
      end else begin
         if (cfg_take && lnk.cfg_we && lnk.cfg_addr == boot_seq_pkg::REG_SCRATCH) begin
            ctl_byte_q <= lnk.cfg_wdata[boot_seq_pkg::SCR_CTRL_LSB +: 8];
         end
         if (state_q == S_HALT && boot_mode_q == boot_seq_pkg::MODE_SVC && halt_req) begin
            status_q <= boot_seq_pkg::ABOUT_TO_HALT;
         end else if (state_q == S_SCAN && boot_mode_q == boot_seq_pkg::MODE_LINK_INIT
                      && (halt_req || all_done)) begin
            status_q <= boot_seq_pkg::ABOUT_TO_HALT;
         end
      end
   end

   // Address decoder entries and software reset register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sad_flash_q <= '0;
         bios_seg_q <= '0;
         region_q <= '0;
         sw_reset_q <= 3'h0;
      end else begin
         if (state_q == S_DISPATCH && boot_mode_q == boot_seq_pkg::MODE_FLASH) begin
            sad_flash_q[boot_seq_pkg::NID_W-1:0] <= LOCAL_NID;
            sad_flash_q[boot_seq_pkg::SAD_EN_BIT] <= 1'b1;
            bios_seg_q[boot_seq_pkg::SEG_W-1:0] <= '1;
         end else if (fw_fire) begin
            region_q[boot_seq_pkg::RGN_FW_LSB +: boot_seq_pkg::NID_W] <=
               link_fw_nid[idx_q*boot_seq_pkg::NID_W +: boot_seq_pkg::NID_W];
            region_q[boot_seq_pkg::RGN_BIOS_LSB +: boot_seq_pkg::NID_W] <=
               link_fw_nid[idx_q*boot_seq_pkg::NID_W +: boot_seq_pkg::NID_W];
            region_q[boot_seq_pkg::RGN_IOHUB_LSB +: boot_seq_pkg::NID_W] <=
               link_fw_nid[idx_q*boot_seq_pkg::NID_W +: boot_seq_pkg::NID_W];
            region_q[boot_seq_pkg::RGN_FW_EN_BIT] <= 1'b1;
            sw_reset_q <= boot_seq_pkg::RST_KIND_CORE;
         end else if (cfg_take && lnk.cfg_we) begin
            // Writes by the controller, which may set up its own flash target.
            case (lnk.cfg_addr)
               boot_seq_pkg::REG_SAD_FLASH: sad_flash_q <= lnk.cfg_wdata;
               boot_seq_pkg::REG_BIOS_SEG: bios_seg_q <= lnk.cfg_wdata;
               boot_seq_pkg::REG_REGION: region_q <= lnk.cfg_wdata;
               boot_seq_pkg::REG_SW_RESET: sw_reset_q <= lnk.cfg_wdata[2:0];
               default: sw_reset_q <= sw_reset_q;
            endcase
         end
      end
   end

   // Configuration port answers one cycle after a request is taken.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_ack_q <= 1'b0;
         cfg_rdata_q <= '0;
      end else begin
         cfg_ack_q <= cfg_take;
         if (cfg_take) begin
            case (lnk.cfg_addr)
               boot_seq_pkg::REG_SCRATCH: cfg_rdata_q <= {16'h0000, ctl_byte_q, status_q};
               boot_seq_pkg::REG_SAD_FLASH: cfg_rdata_q <= sad_flash_q;
               boot_seq_pkg::REG_BIOS_SEG: cfg_rdata_q <= bios_seg_q;
               boot_seq_pkg::REG_REGION: cfg_rdata_q <= region_q;
               boot_seq_pkg::REG_SW_RESET: cfg_rdata_q <= {29'h0, sw_reset_q};
               boot_seq_pkg::REG_ROUTES: cfg_rdata_q <= 32'(done_q);
               boot_seq_pkg::REG_MODE: cfg_rdata_q <= {27'h0, state_q, boot_mode_q};
               default: cfg_rdata_q <= '0;
            endcase
         end
      end
   end

   // Core control: halted in halt state, alias cleared by a core-only reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_halt_q <= 1'b0;
         alias_q <= 1'b1;
         core_reset_q <= 1'b0;
      end else begin
         core_reset_q <= core_evt && state_q != S_CAPTURE;
         if (core_evt && state_q != S_CAPTURE) begin
            alias_q <= 1'b0;
            core_halt_q <= 1'b0;
         end else begin
            core_halt_q <= state_q == S_HALT;
         end
      end
   end

endmodule

// ===== hw/boot_seq_controller.sv
// Controlling party: service processor or remote socket, driven by software over AHB-Lite.
// Assumes a single AHB-Lite master and that this slave's hreadyout is the bus hready.
`timescale 1ns/1ps
module boot_seq_controller (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave port.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout_q,
   output logic hresp_q,
   output logic [31:0] hrdata_q,
   // Link to the socket.
   boot_link_if.ctl lnk
);

   // Takeover states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_HALT_WR = 3'b001,
      H_POLL = 3'b011,
      H_CFG = 3'b010,
      H_RESET = 3'b110,
      H_DONE = 3'b111
   } ctl_state_t;

   ctl_state_t state_q; // Takeover state.
   logic dp_we_q; // Data phase of a write is pending.
   logic [31:0] dp_addr_q; // Address of that write.
   logic [boot_seq_pkg::NID_W-1:0] flash_nid_q; // Flash target to program.
   logic [7:0] seen_status_q; // Last status byte read back.
   logic [7:0] nb_cnt_q; // Route-back messages acknowledged.
   logic cfg_req_q;
   logic cfg_we_q;
   logic [boot_seq_pkg::ADDR_W-1:0] cfg_addr_q;
   logic [boot_seq_pkg::DATA_W-1:0] cfg_wdata_q;
   logic core_rst_q;
   logic nb_ack_q;
   logic ap_take; // AHB address phase taken.
   logic go; // Software starts a takeover.

   assign ap_take = hsel && htrans == boot_seq_pkg::HTRANS_NONSEQ && hready;
   assign go = dp_we_q && dp_addr_q == boot_seq_pkg::AHB_CTRL && hwdata[boot_seq_pkg::CTL_GO_BIT];
   assign lnk.cfg_req = cfg_req_q;
   assign lnk.cfg_we = cfg_we_q;
   assign lnk.cfg_addr = cfg_addr_q;
   assign lnk.cfg_wdata = cfg_wdata_q;
   assign lnk.core_rst = core_rst_q;
   assign lnk.nb_ack = nb_ack_q;

   // AHB-Lite slave: no wait states, always OKAY, read data loaded at the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
         hrdata_q <= 32'h0000_0000;
         dp_we_q <= 1'b0;
         dp_addr_q <= 32'h0000_0000;
         flash_nid_q <= '0;
      end else begin
         dp_we_q <= ap_take && hwrite && hsize == 3'h2;
         if (ap_take) begin
            dp_addr_q <= haddr;
            case (haddr)
               boot_seq_pkg::AHB_CTRL: hrdata_q <= {16'h0000, flash_nid_q, 8'h00};
               boot_seq_pkg::AHB_STATUS: hrdata_q <= {13'h0000, state_q, nb_cnt_q, seen_status_q};
               default: hrdata_q <= 32'h0000_0000;
            endcase
         end
         if (dp_we_q && dp_addr_q == boot_seq_pkg::AHB_CTRL) begin
            flash_nid_q <= hwdata[boot_seq_pkg::CTL_NID_LSB +: boot_seq_pkg::NID_W];
         end
      end
   end

   // Takeover: halt request, wait for status, configure flash, core-only reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= H_IDLE;
         cfg_req_q <= 1'b0;
         cfg_we_q <= 1'b0;
         cfg_addr_q <= '0;
         cfg_wdata_q <= '0;
         core_rst_q <= 1'b0;
         seen_status_q <= 8'h00;
      end else begin
         core_rst_q <= 1'b0;
         case (state_q)
            H_IDLE, H_DONE: begin
               if (go) begin
                  state_q <= H_HALT_WR;
               end
            end
            H_HALT_WR: begin
               if (!cfg_req_q) begin
                  cfg_req_q <= 1'b1;
                  cfg_we_q <= 1'b1;
                  cfg_addr_q <= boot_seq_pkg::REG_SCRATCH;
                  cfg_wdata_q <= 32'(boot_seq_pkg::HALT_REQ) << boot_seq_pkg::SCR_CTRL_LSB;
               end else if (lnk.cfg_ack) begin
                  cfg_req_q <= 1'b0;
                  state_q <= H_POLL;
               end
            end
            H_POLL: begin
               // Only the scratchpad is touched until the status byte shows the halt.
               if (!cfg_req_q) begin
                  cfg_req_q <= 1'b1;
                  cfg_we_q <= 1'b0;
                  cfg_addr_q <= boot_seq_pkg::REG_SCRATCH;
               end else if (lnk.cfg_ack) begin
                  cfg_req_q <= 1'b0;
                  seen_status_q <= lnk.cfg_rdata[boot_seq_pkg::SCR_STATUS_LSB +: 8];
                  if (lnk.cfg_rdata[boot_seq_pkg::SCR_STATUS_LSB +: 8]
                      == boot_seq_pkg::ABOUT_TO_HALT) begin
                     state_q <= H_CFG;
                  end
               end
            end
            H_CFG: begin
               if (!cfg_req_q) begin
                  cfg_req_q <= 1'b1;
                  cfg_we_q <= 1'b1;
                  cfg_addr_q <= boot_seq_pkg::REG_SAD_FLASH;
                  cfg_wdata_q <= (32'h1 << boot_seq_pkg::SAD_EN_BIT) | 32'(flash_nid_q);
               end else if (lnk.cfg_ack) begin
                  cfg_req_q <= 1'b0;
                  state_q <= H_RESET;
               end
            end
            H_RESET: begin
               core_rst_q <= 1'b1;
               state_q <= H_DONE;
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   // Neighbour port: accepts each route-back write one cycle after it appears.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nb_ack_q <= 1'b0;
         nb_cnt_q <= 8'h00;
      end else begin
         nb_ack_q <= lnk.nb_req && !nb_ack_q;
         if (lnk.nb_req && !nb_ack_q) begin
            nb_cnt_q <= nb_cnt_q + 8'h01;
         end
      end
   end

endmodule

// ===== testbench/boot_seq_assertions.sv
// Concurrent checks on the boot link between socket and controller.
// Assumes it sits beside the link interface and sees its signals.
`timescale 1ns/1ps
module boot_seq_assertions (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Link signals.
   input wire logic cfg_req,
   input wire logic cfg_ack,
   input wire logic core_rst,
   input wire logic nb_req,
   input wire logic nb_ack,
   input wire logic [boot_seq_pkg::NB_W-1:0] nb_data
);
   // All checks run on hclk and rest while reset is low.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   take_answer_a: assert property (cfg_req && !cfg_ack |=> cfg_ack)
      else $error("config access not answered");
   ack_cause_a: assert property (cfg_ack |-> $past(cfg_req) ##1 !cfg_ack)
      else $error("config ack without request");
   req_drop_a: assert property (cfg_ack |=> !cfg_req)
      else $error("config request held past ack");
   rst_pulse_a: assert property (core_rst |=> !core_rst)
      else $error("core reset longer than one cycle");
   nb_hold_a: assert property (nb_req && !nb_ack |=> nb_req && $stable(nb_data))
      else $error("route message changed before ack");
   nb_answer_a: assert property (nb_req && !nb_ack |=> nb_ack)
      else $error("route message not acknowledged");
   nb_drop_a: assert property (nb_ack |=> !nb_req)
      else $error("route message held past ack");
   nb_source_a: assert property (nb_req |-> nb_data[boot_seq_pkg::NB_SRC_SIU_BIT])
      else $error("route message lacks interface unit source");
endmodule

// ===== testbench/tb_strap_boot_mode_sequencer.sv
// Bench joining the socket sequencer and its controller across the boot link.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
module tb_strap_boot_mode_sequencer;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [1:0] boot_strap = 2'h0;
   logic [15:0] link_state = 16'h4444;
   logic [3:0] link_fw_agent = 4'h0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready, halt, alias_on, core_pulse;
   logic [1:0] mode;
   logic [7:0] status;
   logic [31:0] system_address_decoder, hrdata, rd;
   int n_errors = 0;
   int samples_checked = 0;
   int n_pulses = 0; // Core-only reset pulses seen since time zero.
   boot_link_if boot_link_if_i ();
   // Clock of 20 ns.
   always #10 hclk = ~hclk;
   // Counts the socket's core-only reset pulses away from the launching edge.
   always @(negedge hclk) begin
      if (core_pulse === 1'b1) begin
         n_pulses++;
      end
   end
   boot_seq_device boot_seq_device_i (.hclk(hclk), .hresetn(hresetn), .boot_strap(boot_strap),
      .link_state(link_state), .link_agents(16'h1111), .link_fw_agent(link_fw_agent),
      .link_fw_nid(32'h33), .lnk(boot_link_if_i.dev), .core_halt_q(halt), .alias_q(alias_on),
      .core_reset_q(core_pulse), .boot_mode_q(mode), .status_q(status), .sad_flash_q(system_address_decoder));
   boot_seq_controller boot_seq_controller_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout_q(hready), .hresp_q(), .hrdata_q(hrdata),
      .lnk(boot_link_if_i.ctl));
   boot_seq_assertions boot_seq_assertions_i (.hclk(hclk), .hresetn(hresetn),
      .cfg_req(boot_link_if_i.cfg_req), .cfg_ack(boot_link_if_i.cfg_ack),
      .core_rst(boot_link_if_i.core_rst), .nb_req(boot_link_if_i.nb_req),
      .nb_ack(boot_link_if_i.nb_ack), .nb_data(boot_link_if_i.nb_data));
   // Compares one value and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single word AHB transfer; each phase holds until hready.
   task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= we;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Resets with a strap value, then moves the strap to show it is held.
   task automatic start(input logic [1:0] m);
      @(posedge hclk);
      hresetn <= 1'b0;
      boot_strap <= m;
      link_state <= 16'h4444;
      link_fw_agent <= 4'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      boot_strap <= ~m;
      repeat (4) @(posedge hclk);
   endtask
   // Waits for the flow to end, bounded by the watchdog, then reads the status word.
   task automatic settle();
      while (halt !== 1'b1 && alias_on !== 1'b0) @(posedge hclk);
      xfer(1'b0, 32'h4, 32'h0);
      @(negedge hclk);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("mismatches %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      report_and_stop();
   end
   // Runs each boot flow in turn.
   initial begin
      start(2'h0);
      chk({30'h0, mode}, 32'h0);
      chk(system_address_decoder, 32'h100);
      chk({31'h0, halt}, 32'h1);
      $display("test flash boot done");
      start(2'h1);
      chk({31'h0, halt}, 32'h1);
      xfer(1'b1, 32'h0, 32'h5a01);
      while (alias_on !== 1'b0) @(posedge hclk);
      settle();
      chk({24'h0, status}, 32'hf8);
      chk(rd & 32'hff, 32'hf8);
      chk(system_address_decoder, 32'h15a);
      chk({30'h0, alias_on, halt}, 32'h0);
      $display("test service boot done");
      start(2'h2);
      chk({31'h0, halt}, 32'h0);
      xfer(1'b1, 32'h0, 32'h5a01);
      while (alias_on !== 1'b0) @(posedge hclk);
      settle();
      chk({24'h0, status}, 32'hf8);
      chk(system_address_decoder, 32'h15a);
      chk({30'h0, alias_on, halt}, 32'h0);
      $display("test link init halt done");
      start(2'h2);
      link_state <= 16'h3333;
      settle();
      chk({24'h0, status}, 32'hf8);
      chk((rd >> 8) & 32'hff, 32'h4);
      chk({16'h0, boot_link_if_i.nb_data}, 32'h1100);
      $display("test link init done");
      start(2'h3);
      link_fw_agent <= 4'h3;
      link_state <= 16'h4443;
      settle();
      chk({30'h0, alias_on, halt}, 32'h0);
      chk((rd >> 8) & 32'hff, 32'h1);
      chk(boot_seq_device_i.region_q, 32'h0133_3333);
      chk({29'h0, boot_seq_device_i.sw_reset_q}, 32'h1);
      $display("test link boot firmware done");
      start(2'h3);
      xfer(1'b1, 32'h0, 32'h5a01);
      settle();
      chk({24'h0, status}, 32'h0);
      chk({30'h0, alias_on, halt}, 32'h3);
      chk(rd & 32'hff, 32'h0);
      $display("test link boot halt done");
      start(2'h3);
      link_state <= 16'h3333;
      settle();
      chk({30'h0, alias_on, halt}, 32'h3);
      chk((rd >> 8) & 32'hff, 32'h4);
      chk({16'h0, boot_link_if_i.nb_data}, 32'h1300);
      chk(n_pulses, 32'h3);
      $display("test link boot done");
      report_and_stop();
   end
endmodule
